// *** verilog/ctlpd_device.sv ***
// Converter end: tri-level pin decode and serial register port.
`timescale 1ns/100ps
module ctlpd_device
  import ctlpd_pkg::*;
#(
  parameter int NREGS = 16  // Register file depth.
)
(
  input  wire logic         link_clk,        // Converter clock.
  input  wire logic         nrst,            // Synchronous reset.
  input  wire logic         ce,              // Clock enable.
  ctlpd_if.dev              pins,            // Configuration pins.
  input  wire logic [3:0]   rd_addr,         // Register read address.
  output logic      [15:0]  rd_data_q,       // Register read data.
  output logic              ext_mode_q,      // Extended mode active.
  output logic              fs_normal_q,     // Normal full-scale range.
  output logic              swing_normal_q,  // Normal output swing.
  output logic              launch_rising_q, // Launch on rising edge.
  output logic              ddr_q,           // Double data rate clock.
  output logic              cal_long_q,      // Long calibration delay.
  output logic              des_pin_q,       // Dual-edge by pin.
  output logic      [15:0]  dual_edge_q,     // Dual-edge register.
  output logic              wr_done_q,       // Register written pulse.
  output logic              frame_err_q      // Bad frame pulse.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,  // Waiting for select.
    RX_SHIFT = 2'b10   // Collecting a frame.
  } ctlpd_rx_t;

  logic [7:0]   sync1_q;     // First stage, low sense over high.
  logic [7:0]   sync2_q;     // Second stage, safe to read.
  ctlpd_lvl_t   lvl [CTLPD_PINS];  // Resolved pin levels.
  logic         ext;         // Mode pin floating.
  logic         sclk_prev_q; // Serial clock one cycle back.
  logic         sclk_rise;   // Serial clock rising edge.
  logic         sel_act;     // Serial select asserted.
  ctlpd_rx_t    rx_q;        // Receiver state.
  logic [19:0]  shift_q;     // Incoming frame.
  logic [4:0]   cnt_q;       // Bits received.
  logic         ovf_q;       // Too many bits in frame.
  logic         commit;      // Frame complete, write it.
  logic         abort;       // Frame ended badly.
  logic [RDATA_W-1:0] regs_q [NREGS];  // Register file.

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are set from another clock, so each passes two flops.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (ce) begin
      sync1_q <= {pins.pin_lo, pins.pin_hi};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Tri-level resolution
  // ----------------------------------------------------------------
  // A pin seen neither high nor low is taken as floating.
  for (genvar i = 0; i < CTLPD_PINS; i++) begin : g_res
    assign lvl[i] = sync2_q[i]     ? LVL_HI :
                    sync2_q[4 + i] ? LVL_LO : LVL_FLT;
  end

  // Floating mode pin selects extended control.
  assign ext = (lvl[PIN_MODE] == LVL_FLT);

  // Mode flag follows the mode pin.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      ext_mode_q <= 1'b0;
    end else if (ce) begin
      ext_mode_q <= ext;
    end
  end

  // ----------------------------------------------------------------
  // Pin-strapped settings
  // ----------------------------------------------------------------
  // Settings track the pins only in strapped mode and hold otherwise.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      fs_normal_q     <= 1'b1;
      swing_normal_q  <= 1'b1;
      launch_rising_q <= 1'b1;
      ddr_q           <= 1'b0;
      cal_long_q      <= 1'b0;
      des_pin_q       <= 1'b0;
    end else if (ce && !ext) begin
      // Mode pin level picks the input range.
      fs_normal_q <= (lvl[PIN_MODE] == LVL_HI);
      // Swing pin has no floating meaning, so hold then.
      if (lvl[PIN_SWING] != LVL_FLT) begin
        swing_normal_q <= (lvl[PIN_SWING] == LVL_HI);
      end
      // Edge pin: level picks the edge, floating picks DDR.
      unique case (lvl[PIN_EDGE])
        LVL_HI: begin
          launch_rising_q <= 1'b1;
          ddr_q           <= 1'b0;
        end
        LVL_LO: begin
          launch_rising_q <= 1'b0;
          ddr_q           <= 1'b0;
        end
        default: ddr_q <= 1'b1;
      endcase
      // Delay pin: level picks the delay, floating dual-edge.
      unique case (lvl[PIN_CAL])
        LVL_HI: begin
          cal_long_q <= 1'b1;
          des_pin_q  <= 1'b0;
        end
        LVL_LO: begin
          cal_long_q <= 1'b0;
          des_pin_q  <= 1'b0;
        end
        default: des_pin_q <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  // Pins serve as clock, data and active-low select only here.
  assign sel_act   = ext && (lvl[PIN_CAL] == LVL_LO);
  assign sclk_rise = ext && sync2_q[PIN_SWING] && !sclk_prev_q;
  assign commit    = (rx_q == RX_SHIFT) && !sel_act &&
                     (cnt_q == FRAME_BITS) && !ovf_q;
  assign abort     = (rx_q == RX_SHIFT) && !sel_act && !commit;

  // Previous serial clock level for edge detection.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sync2_q[PIN_SWING];
    end
  end

  // Frame receiver: bits shift in MSB first on serial clock rise.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      rx_q    <= RX_IDLE;
      shift_q <= 20'h0_0000;
      cnt_q   <= 5'h00;
      ovf_q   <= 1'b0;
    end else if (ce) begin
      unique case (rx_q)
        RX_IDLE: begin
          if (sel_act) begin
            cnt_q <= 5'h00;
            ovf_q <= 1'b0;
            rx_q  <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (!sel_act) begin
            rx_q <= RX_IDLE;
          end else if (sclk_rise) begin
            shift_q <= {shift_q[18:0], sync2_q[PIN_EDGE]};
            if (cnt_q == FRAME_BITS) begin
              ovf_q <= 1'b1;  // Extra bits spoil the frame.
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Completion and error pulses.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      wr_done_q   <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (ce) begin
      wr_done_q   <= commit;
      frame_err_q <= abort;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Dual-edge register resets to its default; the rest to zero.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      for (int r = 0; r < NREGS; r++) begin
        regs_q[r] <= (r == int'(DES_ADDR)) ? DES_RESET : 16'h0000;
      end
    end else if (ce && commit) begin
      regs_q[shift_q[19:16]] <= shift_q[15:0];
    end
  end

  // Registered read port.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      rd_data_q <= 16'h0000;
    end else if (ce) begin
      rd_data_q <= regs_q[rd_addr];
    end
  end

  assign dual_edge_q = regs_q[DES_ADDR];

endmodule

// *** verilog/ctlpd_pkg.sv ***
// Shared constants and types for the control mode pin decoder.
package ctlpd_pkg;

  // ----------------------------------------------------------------
  // Configuration pins
  // ----------------------------------------------------------------
  localparam int CTLPD_PINS = 4;    // Number of configuration pins.
  localparam int PIN_SWING  = 0;    // Swing select, serial clock.
  localparam int PIN_EDGE   = 1;    // Edge select, serial data.
  localparam int PIN_CAL    = 2;    // Delay select, serial select.
  localparam int PIN_MODE   = 3;    // Mode and full-scale select.

  // Resolved level of one tri-level pin.
  typedef logic [1:0] ctlpd_lvl_t;
  localparam ctlpd_lvl_t LVL_LO  = 2'h0;  // Driven low.
  localparam ctlpd_lvl_t LVL_HI  = 2'h1;  // Driven high.
  localparam ctlpd_lvl_t LVL_FLT = 2'h2;  // Left floating.

  // ----------------------------------------------------------------
  // Serial frame and device register file
  // ----------------------------------------------------------------
  localparam int         RADDR_W     = 4;        // Register address.
  localparam int         RDATA_W     = 16;       // Register data.
  localparam logic [4:0] FRAME_BITS  = 5'h14;    // Address plus data.
  localparam logic [3:0] DES_ADDR    = 4'hd;     // Dual-edge enable.
  localparam logic [15:0] DES_RESET  = 16'h3fff; // Its default value.
  localparam logic [15:0] USER_MASK  = 16'h6e0e; // The 8 user regs.

  // ----------------------------------------------------------------
  // Host command registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // Pin level codes.
  localparam logic [7:0] CMD_OFS    = 8'h04;  // Serial write order.
  localparam logic [7:0] STAT_OFS   = 8'h08;  // Host status.
  localparam int         CTRL_MODE  = 0;      // Mode pin code field.
  localparam int         CTRL_SWING = 2;      // Swing pin code field.
  localparam int         CTRL_EDGE  = 4;      // Edge pin code field.
  localparam int         CTRL_CAL   = 6;      // Delay pin code field.
  localparam logic [7:0] CTRL_RESET = 8'h15;  // All high, delay low.
  localparam int         STAT_BUSY  = 0;      // Frame in flight.
  localparam int         STAT_REFU  = 1;      // Sticky refusal.
  localparam int         STAT_ALL   = 2;      // All user regs written.
  localparam int         STAT_WMASK = 16;     // Written address mask.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 20;  // Host clock period.
  localparam int SCLK_HALF_NS  = 80;  // Least serial clock half period.
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

endpackage

// *** verilog/ctlpd_if.sv ***
// Pin bundle joining the host end and the converter end.
`timescale 1ns/100ps
interface ctlpd_if;

  logic [3:0] pin_val;   // Level each pin is driven to.
  logic [3:0] pin_oe_n;  // Low while the host drives the pin.
  logic [3:0] pin_hi;    // Pin seen driven high.
  logic [3:0] pin_lo;    // Pin seen driven low.

  // Window sensing: an undriven pin reads neither high nor low.
  assign pin_hi = ~pin_oe_n & pin_val;
  assign pin_lo = ~pin_oe_n & ~pin_val;

  modport host (output pin_val, output pin_oe_n);
  modport dev  (input pin_hi, input pin_lo);

endinterface

// *** verilog/ctlpd_host.sv ***
// Host end: drives the configuration pins and the serial port.
`timescale 1ns/100ps
module ctlpd_host
  import ctlpd_pkg::*;
(
  input  wire logic        clock,     // System clock.
  input  wire logic        nrst,      // Synchronous reset.
  input  wire logic        ce,        // Clock enable.
  input  wire logic [7:0]  addr,      // Register byte address.
  input  wire logic [31:0] wdata,     // Write data.
  input  wire logic        wr,        // Write strobe.
  input  wire logic        rd,        // Read strobe.
  output logic      [31:0] rdata,     // Read data, one cycle later.
  output logic             cfg_ready, // All user regs written.
  ctlpd_if.host            pins       // Configuration pins.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001, H_SEL = 5'b00010, H_LOW = 5'b00100,
    H_HIGH = 5'b01000, H_END = 5'b10000
  } ctlpd_hst_t;

  ctlpd_hst_t  state_q;     // Serial sequencer state.
  logic [7:0]  ctrl_q;      // Pin level codes.
  logic [19:0] cmd_q;       // Last accepted serial order.
  logic [19:0] shift_q;     // Outgoing frame, MSB first.
  logic [4:0]  bit_q;       // Bits sent in this frame.
  logic [7:0]  div_q;       // Half period timer.
  logic        refused_q;   // Sticky refusal flag.
  logic [15:0] written_q;   // Addresses written at least once.
  logic [3:0]  pval_q;      // Registered pin levels.
  logic [3:0]  poe_n_q;     // Registered pin enables.
  logic [3:0]  pval_d;      // Next pin levels.
  logic [3:0]  poe_n_d;     // Next pin enables.
  logic        busy;        // A frame is in flight.
  logic        ext;         // Extended mode chosen.
  logic        half_done;   // Half period elapsed.
  logic        cmd_wr;      // Order write seen.
  logic        cmd_ok;      // Order may be sent.
  logic        ctrl_wr;     // Level code write seen.

  assign busy      = (state_q != H_IDLE);
  assign ext       = (ctrl_q[CTRL_MODE +: 2] == LVL_FLT);
  assign half_done = (div_q == 8'(SCLK_HALF_CYC - 1));
  assign cfg_ready = &(written_q | ~USER_MASK);
  assign cmd_wr    = wr && (addr == CMD_OFS);
  assign ctrl_wr   = wr && (addr == CTRL_OFS);
  // Dual-edge register must first get its default, and other values
  // only once every user register has been written.
  assign cmd_ok    = !busy && ext &&
                     !(wdata[19:16] == DES_ADDR && !cfg_ready &&
                       wdata[15:0] != DES_RESET);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Level codes change only between frames.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce && ctrl_wr && !busy) begin
      ctrl_q <= wdata[7:0];
    end
  end

  // Accepted orders and the record of written addresses.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd_q     <= 20'h0_0000;
      written_q <= 16'h0000;
    end else if (ce && cmd_wr && cmd_ok) begin
      cmd_q <= wdata[19:0];
      written_q[wdata[19:16]] <= 1'b1;
    end
  end

  // Refusal is sticky; a new refusal wins over a clear.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      refused_q <= 1'b0;
    end else if (ce) begin
      if ((cmd_wr && !cmd_ok) || (ctrl_wr && busy)) begin
        refused_q <= 1'b1;
      end else if (wr && addr == STAT_OFS && wdata[STAT_REFU]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Read data stand in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        unique case (addr)
          CTRL_OFS: rdata[7:0]  <= ctrl_q;
          CMD_OFS:  rdata[19:0] <= cmd_q;
          STAT_OFS: begin
            rdata[STAT_BUSY]         <= busy;
            rdata[STAT_REFU]         <= refused_q;
            rdata[STAT_ALL]          <= cfg_ready;
            rdata[STAT_WMASK +: 16]  <= written_q;
          end
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial sequencer
  // ----------------------------------------------------------------
  // Select, then 20 clock periods, then a gap, each half a period.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= H_IDLE;
      shift_q <= 20'h0_0000;
      bit_q   <= 5'h00;
      div_q   <= 8'h00;
    end else if (ce) begin
      div_q <= half_done ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        H_IDLE: begin
          div_q <= 8'h00;
          if (cmd_wr && cmd_ok) begin
            shift_q <= wdata[19:0];
            bit_q   <= 5'h00;
            state_q <= H_SEL;
          end
        end
        H_SEL: if (half_done) state_q <= H_LOW;
        H_LOW: if (half_done) state_q <= H_HIGH;
        H_HIGH: begin
          if (half_done) begin
            shift_q <= {shift_q[18:0], 1'b0};
            bit_q   <= bit_q + 5'h01;
            state_q <= (bit_q == FRAME_BITS - 5'h01) ? H_END : H_LOW;
          end
        end
        H_END: if (half_done) state_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Past reset, pins never float except the mode and edge pins when asked.
  always_comb begin
    pval_d  = 4'h0;
    poe_n_d = 4'h0;
    pval_d[PIN_MODE]  = (ctrl_q[CTRL_MODE +: 2] == LVL_HI);
    poe_n_d[PIN_MODE] = ext;
    if (ext) begin
      pval_d[PIN_SWING] = (state_q == H_HIGH);
      pval_d[PIN_EDGE]  = shift_q[19];
      pval_d[PIN_CAL]   = !(state_q inside {H_SEL, H_LOW, H_HIGH});
    end else begin
      // Swing pin is always driven; a float code drives high.
      pval_d[PIN_SWING] = (ctrl_q[CTRL_SWING +: 2] != LVL_LO);
      pval_d[PIN_EDGE]  = (ctrl_q[CTRL_EDGE +: 2] == LVL_HI);
      poe_n_d[PIN_EDGE] = (ctrl_q[CTRL_EDGE +: 2] == LVL_FLT);
      // Delay pin is always driven; a float code drives low.
      pval_d[PIN_CAL]   = (ctrl_q[CTRL_CAL +: 2] == LVL_HI);
    end
  end

  // Pin levels leave from flip-flops.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pval_q  <= 4'h0;
      poe_n_q <= 4'hf;
    end else if (ce) begin
      pval_q  <= pval_d;
      poe_n_q <= poe_n_d;
    end
  end

  assign pins.pin_val  = pval_q;
  assign pins.pin_oe_n = poe_n_q;

endmodule

// *** sim/ctlpd_assertions.sv ***
// Concurrent checks on the converter end of the pin decoder.
`timescale 1ns/100ps
module ctlpd_assertions (
  input wire logic       link_clk,        // Converter clock.
  input wire logic       nrst,            // Converter reset, active low.
  input wire logic [3:0] pin_hi,          // Pins seen driven high.
  input wire logic [3:0] pin_lo,          // Pins seen driven low.
  input wire logic       ext_mode_q,      // Extended mode active.
  input wire logic       fs_normal_q,     // Normal full-scale range.
  input wire logic       swing_normal_q,  // Normal output swing.
  input wire logic       launch_rising_q, // Launch on rising edge.
  input wire logic       ddr_q,           // Double data rate clock.
  input wire logic       cal_long_q,      // Long calibration delay.
  input wire logic       wr_done_q,       // Register written pulse.
  input wire logic       frame_err_q      // Bad frame pulse.
);
  // ------------------------------------------------------------
  // Helper terms and sequences
  // ------------------------------------------------------------
  logic strap;  // Mode pin is driven, so pins set everything.
  assign strap = pin_hi[3] | pin_lo[3];
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!nrst);
  // Mode pin floats long enough to pass the synchronisers.
  sequence s_mode_float;
    (!pin_hi[3] && !pin_lo[3]) [*8];
  endsequence
  // Select released at the end of a frame in extended mode.
  sequence s_frame_end;
    ext_mode_q && pin_lo[2] ##1 pin_hi[2];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_mode_float_ext:
    assert property (s_mode_float |-> ext_mode_q)
    else $error("floating mode pin did not give extended mode");
  a_fs_normal:
    assert property (pin_hi[3] [*8] |-> !ext_mode_q && fs_normal_q)
    else $error("mode pin high did not give normal range");
  a_fs_reduced:
    assert property (pin_lo[3] [*8] |-> !ext_mode_q && !fs_normal_q)
    else $error("mode pin low did not give reduced range");
  a_edge_select:
    assert property ((strap && (pin_hi[1] || pin_lo[1])
      && $stable(pin_hi[1])) [*8] |-> launch_rising_q == pin_hi[1] && !ddr_q)
    else $error("launch edge does not follow edge pin");
  a_edge_ddr:
    assert property ((strap && !pin_hi[1] && !pin_lo[1]) [*8] |-> ddr_q)
    else $error("floating edge pin did not give double rate");
  a_cal_delay:
    assert property ((strap && (pin_hi[2] || pin_lo[2])
      && $stable(pin_hi[2])) [*8] |-> cal_long_q == pin_hi[2])
    else $error("delay select does not follow delay pin");
  a_swing_level:
    assert property ((strap && (pin_hi[0] || pin_lo[0])
      && $stable(pin_hi[0])) [*8] |-> swing_normal_q == pin_hi[0])
    else $error("swing does not follow swing pin");
  a_serial_off:
    assert property (strap [*8] |-> !wr_done_q)
    else $error("register written in pin-strapped mode");
  a_write_ext:
    assert property (wr_done_q |-> ext_mode_q)
    else $error("register written outside extended mode");
  a_frame_answer:
    assert property (s_frame_end |-> ##[1:8] (wr_done_q || frame_err_q))
    else $error("frame end got no answer");
endmodule

// *** sim/control_mode_pin_decode_test.sv ***
// Self-checking bench joining the host end to the converter end.
`timescale 1ns/100ps
module control_mode_pin_decode_test;
  import ctlpd_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clock, link_clk;      // Host and converter clocks.
  logic        nrst, link_nrst;      // Resets of the two domains.
  logic        ce, wr, rd;           // Enable and bus strobes.
  logic [7:0]  addr;                 // Host register address.
  logic [31:0] wdata, rdata, v;      // Bus data and read result.
  logic        cfg_ready;            // All user registers written.
  logic [3:0]  rd_addr, ra;          // Converter register address.
  logic [15:0] rd_data_q, dual_edge_q, dv, ev; // Register values.
  logic [1:0]  ed;                   // Edge pin code.
  logic        ext_mode_q, fs_normal_q, swing_normal_q, launch_rising_q;
  logic        ddr_q, cal_long_q, des_pin_q, wr_done_q, frame_err_q;
  int          bad_count = 0;        // Mismatches seen.
  int          cmp_count = 0;        // Comparisons made.
  int          cyc = 0;              // Host cycles since start.
  // ------------------------------------------------------------
  // Design instances and checker
  // ------------------------------------------------------------
  ctlpd_if u_ctlpd_if ();
  ctlpd_host u_ctlpd_host (.clock(clock), .nrst(nrst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cfg_ready(cfg_ready), .pins(u_ctlpd_if));
  ctlpd_device u_ctlpd_device (.link_clk(link_clk), .nrst(link_nrst),
    .ce(ce), .pins(u_ctlpd_if), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
    .ext_mode_q(ext_mode_q), .fs_normal_q(fs_normal_q),
    .swing_normal_q(swing_normal_q), .launch_rising_q(launch_rising_q),
    .ddr_q(ddr_q), .cal_long_q(cal_long_q), .des_pin_q(des_pin_q),
    .dual_edge_q(dual_edge_q), .wr_done_q(wr_done_q),
    .frame_err_q(frame_err_q));
  ctlpd_assertions u_ctlpd_assertions (.link_clk(link_clk),
    .nrst(link_nrst), .pin_hi(u_ctlpd_if.pin_hi),
    .pin_lo(u_ctlpd_if.pin_lo), .ext_mode_q(ext_mode_q),
    .fs_normal_q(fs_normal_q), .swing_normal_q(swing_normal_q),
    .launch_rising_q(launch_rising_q), .ddr_q(ddr_q),
    .cal_long_q(cal_long_q), .wr_done_q(wr_done_q),
    .frame_err_q(frame_err_q));
  // ------------------------------------------------------------
  // Clocks, resets and timeout
  // ------------------------------------------------------------
  // The link clock is offset so its edges never meet the host's.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // Host reset holds two edges, the converter's five to flush syncs.
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
  end
  initial begin
    link_nrst = 1'b0;
    rd_addr = 4'h0;
    repeat (5) @(posedge link_clk);
    link_nrst <= 1'b1;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One-cycle write strobe beside address and data.
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic link_wait(int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic dev_rd(logic [3:0] a, output logic [15:0] d);
    @(posedge link_clk);
    rd_addr <= a;
    link_wait(2);
    d = rd_data_q;
  endtask
  // Orders one serial write and waits until the frame is through.
  task automatic ser_wr(logic [3:0] a, logic [15:0] d);
    wr_reg(CMD_OFS, {12'h000, a, d});
    for (int i = 0; i < 200; i++) begin
      rd_reg(STAT_OFS, v);
      if (v[STAT_BUSY] === 1'b0) break;
    end
    link_wait(10);
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    wait (nrst === 1'b1 && link_nrst === 1'b1);
    link_wait(12);
    // Reset levels: mode, swing and edge high, delay low.
    rd_reg(CTRL_OFS, v);
    check("ctrl_reset", v, {24'h00_0000, CTRL_RESET});
    check("ext_reset", ext_mode_q, 1'b0);
    check("fs_reset", fs_normal_q, 1'b1);
    check("launch_reset", launch_rising_q, 1'b1);
    check("cal_reset", cal_long_q, 1'b0);
    check("des_reset", dual_edge_q, DES_RESET);
    // Pin-strapped table: both mode levels, all pin codes.
    for (int i = 0; i < 6; i++) begin
      ed = 2'(i % 3);
      wr_reg(CTRL_OFS, {24'h0, i == 4, i[0], ed, i[2], i[1], 1'b0, i < 3});
      link_wait(12);
      check("ext_strap", ext_mode_q, 1'b0);
      check("fs_normal", fs_normal_q, i < 3);
      check("swing", swing_normal_q, i > 1);
      check("ddr", ddr_q, ed == 2'h2);
      if (ed != 2'h2) check("launch", launch_rising_q, ed[0]);
      check("cal_long", cal_long_q, i[0]);
      check("des_pin", des_pin_q, 1'b0);
    end
    // A serial order in pin-strapped mode is refused.
    wr_reg(CMD_OFS, 32'h0001_1234);
    rd_reg(STAT_OFS, v);
    check("refused_strap", v[STAT_REFU], 1'b1);
    dev_rd(4'h1, dv);
    check("reg_untouched", dv, 16'h0000);
    wr_reg(STAT_OFS, 32'h0000_0002);
    // Floating mode pin enters extended mode.
    wr_reg(CTRL_OFS, 32'h0000_0016);
    link_wait(12);
    check("ext_mode", ext_mode_q, 1'b1);
    // A first non-default dual-edge write is refused.
    wr_reg(CMD_OFS, {12'h000, DES_ADDR, 16'h0001});
    rd_reg(STAT_OFS, v);
    check("refused_des", v[STAT_REFU], 1'b1);
    check("des_kept", dual_edge_q, DES_RESET);
    wr_reg(STAT_OFS, 32'h0000_0002);
    check("not_ready", cfg_ready, 1'b0);
    // Every user register written once over the serial port.
    for (int a = 0; a < 16; a++) begin
      if (USER_MASK[a]) begin
        ra = a[3:0];
        ev = (ra == DES_ADDR) ? DES_RESET : {ra, ra, ra, ra};
        ser_wr(ra, ev);
        dev_rd(ra, dv);
        check("dev_reg", dv, ev);
      end
    end
    rd_reg(STAT_OFS, v);
    check("wmask", v[31:16], USER_MASK);
    check("all_written", v[STAT_ALL], 1'b1);
    check("no_refusal", v[STAT_REFU], 1'b0);
    check("cfg_ready", cfg_ready, 1'b1);
    // Only now may dual-edge take a setting of its own.
    ser_wr(DES_ADDR, 16'h0000);
    check("des_set", dual_edge_q, 16'h0000);
    // Driving the mode pin again returns to pin-strapped control.
    wr_reg(CTRL_OFS, {24'h00_0000, CTRL_RESET});
    link_wait(12);
    check("ext_left", ext_mode_q, 1'b0);
    summarize();
  end
endmodule
